// >>> core/tfm_monitor.sv
/*
 Thermal fault monitor: external thermistor warning and fault detection,
 sticky fault flags with open-drain alert, masked protection with hiccup
 or latch-off, and die over-temperature shutdown with hysteresis.
 Assumes a same-clock command port from a PMBus engine, a digital
 thermistor voltage in mV and a die temperature in degrees Celsius.
*/
`timescale 1ns/10ps
module tfm_monitor
	import tfm_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic enPin,
	input wire logic hicLatchPin,
	input wire logic softStartActive,
	input wire logic [15:0] thermistorVoltage,
	input wire logic [7:0] dieTemp,
	input wire logic [7:0] cmdCode,
	input wire logic cmdWrite,
	input wire logic cmdRead,
	input wire logic [15:0] cmdData,
	input wire logic clearFaults,
	output logic [15:0] rdData,
	output logic alertLineOut,
	output logic alertLineOe,
	output logic pwmEnable,
	output logic softStartReq,
	output logic latchedOff
);

	// Strict unsigned compare of millivolt values
	function automatic logic belowLimit(input logic [15:0] volts, input logic [15:0] limit);
		belowLimit = volts < limit;
	endfunction

	function automatic logic [15:0] widen(input logic [9:0] bits);
		widen = {6'h00, bits};
	endfunction

	// Enable and strap are asynchronous pins
	logic [SYNC_W-1:0] pinSynced;
	logic enSync;
	logic strapSync;

	tfm_sync u_sync (
		.clk(clk),
		.nrst(nrst),
		.async({hicLatchPin, enPin}),
		.synced(pinSynced)
	);

	assign enSync = pinSynced[0];
	assign strapSync = pinSynced[1];

	// Register file state
	logic [15:0] warnLimit_reg, warnLimit_next;
	logic [15:0] faultLimit_reg, faultLimit_next;
	logic [9:0] flags_reg, flags_next;
	logic [9:0] ignoreBits_reg, ignoreBits_next;
	logic [9:0] reaction_reg, reaction_next;
	logic strapDone_reg, strapDone_next;
	logic [15:0] rdData_reg, rdData_next;

	// Protection state
	tfm_prot_e prot_reg, prot_next;
	logic dieHot_reg, dieHot_next;
	logic pwmEnable_reg, pwmEnable_next;
	logic softStartReq_reg, softStartReq_next;
	logic alertOe_reg, alertOe_next;
	logic alertOut_reg;
	logic latchedOff_reg, latchedOff_next;

	logic warnNow;
	logic faultNow;
	logic detectOn;
	logic dieCooled;
	logic writeFlags;
	logic [9:0] setMask;
	logic [9:0] clearMask;

	// Comparators run every edge; flags gate on soft-start
	assign detectOn = softStartActive;
	assign warnNow = belowLimit(thermistorVoltage, warnLimit_reg);
	assign faultNow = belowLimit(thermistorVoltage, faultLimit_reg);
	assign writeFlags = cmdWrite && (cmdCode == CMD_FAULT_FLAGS);

	// Register file next values
	always_comb begin
		warnLimit_next = warnLimit_reg;
		faultLimit_next = faultLimit_reg;
		ignoreBits_next = ignoreBits_reg;
		reaction_next = reaction_reg;
		strapDone_next = strapDone_reg;
		setMask = '0;
		clearMask = '0;
		flags_next = flags_reg;
		if (!enSync) begin
			// Enable low acts like a recycle of every register
			warnLimit_next = WARN_LIMIT_RST;
			faultLimit_next = FAULT_LIMIT_RST;
			ignoreBits_next = IGNORE_RST;
			reaction_next = REACTION_LATCH_ALL;
			strapDone_next = 1'b0;
			flags_next = FLAGS_RST;
		end else begin
			if (!strapDone_reg) begin
				// Default response comes from the strap pin
				reaction_next = strapSync ? REACTION_HICCUP_ALL : REACTION_LATCH_ALL;
				strapDone_next = 1'b1;
			end
			if (cmdWrite) begin
				case (cmdCode)
					CMD_WARN_LIMIT: begin
						warnLimit_next = cmdData;
					end
					CMD_FAULT_LIMIT: begin
						faultLimit_next = cmdData;
					end
					CMD_IGNORE_BITS: begin
						ignoreBits_next = cmdData[FLAG_W-1:0];
					end
					CMD_REACTION_SEL: begin
						reaction_next = cmdData[FLAG_W-1:0];
					end
					default: begin
						// Unmapped codes leave every register alone
					end
				endcase
			end
			// Host clears: ones written to the flags, or clear-all command
			if (writeFlags) begin
				clearMask = cmdData[FLAG_W-1:0];
			end
			if (clearFaults) begin
				clearMask = '1;
			end
			// Detection ignores the mask; set wins over a same-cycle clear
			if (detectOn && warnNow) begin
				setMask[BIT_EXT_WARN] = 1'b1;
			end
			if (detectOn && faultNow) begin
				setMask[BIT_EXT_FAULT] = 1'b1;
			end
			flags_next = (flags_reg & ~clearMask) | setMask;
		end
	end

	// Read data next value, one cycle after the read strobe
	always_comb begin
		rdData_next = rdData_reg;
		if (!enSync) begin
			rdData_next = 16'h0000;
		end else if (cmdRead) begin
			case (cmdCode)
				CMD_WARN_LIMIT: begin
					rdData_next = warnLimit_reg;
				end
				CMD_FAULT_LIMIT: begin
					rdData_next = faultLimit_reg;
				end
				CMD_FAULT_FLAGS: begin
					rdData_next = widen(flags_reg);
				end
				CMD_IGNORE_BITS: begin
					rdData_next = widen(ignoreBits_reg);
				end
				CMD_REACTION_SEL: begin
					rdData_next = widen(reaction_reg);
				end
				default: begin
					rdData_next = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdData_reg <= 16'h0000;
		end else begin
			rdData_reg <= rdData_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			warnLimit_reg <= WARN_LIMIT_RST;
			faultLimit_reg <= FAULT_LIMIT_RST;
			flags_reg <= FLAGS_RST;
			ignoreBits_reg <= IGNORE_RST;
			reaction_reg <= REACTION_LATCH_ALL;
			strapDone_reg <= 1'b0;
		end else begin
			warnLimit_reg <= warnLimit_next;
			faultLimit_reg <= faultLimit_next;
			flags_reg <= flags_next;
			ignoreBits_reg <= ignoreBits_next;
			reaction_reg <= reaction_next;
			strapDone_reg <= strapDone_next;
		end
	end

	// Die shutdown with hysteresis; PWM stays off while hot
	always_comb begin
		dieHot_next = dieHot_reg;
		dieCooled = 1'b0;
		if (!enSync) begin
			dieHot_next = 1'b0;
		end else if (!dieHot_reg && (dieTemp >= DIE_SHUTDOWN_C)) begin
			dieHot_next = 1'b1;
		end else if (dieHot_reg && (dieTemp < DIE_RESUME_C)) begin
			dieHot_next = 1'b0;
			dieCooled = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			dieHot_reg <= 1'b0;
		end else begin
			dieHot_reg <= dieHot_next;
		end
	end

	// Protection next values
	always_comb begin
		prot_next = prot_reg;
		softStartReq_next = dieCooled;
		case (prot_reg)
			TFM_RUN: begin
				// Warning takes no part here; only unmasked faults act
				if (detectOn && faultNow && !ignoreBits_reg[BIT_EXT_FAULT]) begin
					prot_next = reaction_reg[BIT_EXT_FAULT] ? TFM_HICCUP : TFM_LATCHED;
				end
			end
			TFM_HICCUP: begin
				if (!faultNow) begin
					prot_next = TFM_RUN;
					softStartReq_next = 1'b1;
				end
			end
			TFM_LATCHED: begin
				prot_next = TFM_LATCHED;
			end
			default: begin
				prot_next = TFM_LATCHED;
			end
		endcase
		// Enable low restarts the state as a recycle would
		if (!enSync) begin
			prot_next = TFM_RUN;
			softStartReq_next = 1'b0;
		end
		// PWM needs enable, the protection state in run and a cool die
		pwmEnable_next = enSync && (prot_next == TFM_RUN) && !dieHot_next;
		latchedOff_next = prot_next == TFM_LATCHED;
		alertOe_next = |flags_next;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			prot_reg <= TFM_RUN;
			pwmEnable_reg <= 1'b0;
			softStartReq_reg <= 1'b0;
			alertOe_reg <= 1'b0;
			alertOut_reg <= 1'b0;
			latchedOff_reg <= 1'b0;
		end else begin
			prot_reg <= prot_next;
			pwmEnable_reg <= pwmEnable_next;
			softStartReq_reg <= softStartReq_next;
			alertOe_reg <= alertOe_next;
			alertOut_reg <= 1'b0;
			latchedOff_reg <= latchedOff_next;
		end
	end

	assign rdData = rdData_reg;
	// Open-drain alert: value always low, enable drives it
	assign alertLineOut = alertOut_reg;
	assign alertLineOe = alertOe_reg;
	assign pwmEnable = pwmEnable_reg;
	assign softStartReq = softStartReq_reg;
	assign latchedOff = latchedOff_reg;

endmodule

// >>> core/tfm_pkg.sv
/*
 Constants for the thermal fault monitor: command codes, field positions,
 reset values, temperature figures and the protection state encoding.
 Assumes a command port driven by a PMBus engine on the same clock.
*/
package tfm_pkg;

	// Command codes of the register file
	localparam logic [7:0] CMD_FAULT_LIMIT = 8'h4F;
	localparam logic [7:0] CMD_WARN_LIMIT = 8'h51;
	localparam logic [7:0] CMD_FAULT_FLAGS = 8'hD0;
	localparam logic [7:0] CMD_IGNORE_BITS = 8'hD1;
	localparam logic [7:0] CMD_REACTION_SEL = 8'hD2;

	localparam int REG_W = 16;
	localparam int FLAG_W = 10;
	localparam int BIT_EXT_WARN = 1;
	localparam int BIT_EXT_FAULT = 3;

	// Limits in millivolts: 450 mV and 300 mV
	localparam logic [15:0] WARN_LIMIT_RST = 16'h01C2;
	localparam logic [15:0] FAULT_LIMIT_RST = 16'h012C;
	localparam logic [9:0] FLAGS_RST = 10'h000;
	localparam logic [9:0] IGNORE_RST = 10'h009;
	localparam logic [9:0] REACTION_LATCH_ALL = 10'h000;
	localparam logic [9:0] REACTION_HICCUP_ALL = 10'h3FF;

	// Die temperature in degrees Celsius
	localparam logic [7:0] DIE_SHUTDOWN_C = 8'hA0;
	localparam logic [7:0] DIE_RESUME_C = 8'h91;

	localparam int SYNC_W = 2;

	typedef enum logic [1:0] {
		TFM_RUN = 2'b00,
		TFM_HICCUP = 2'b01,
		TFM_LATCHED = 2'b11
	} tfm_prot_e;

endpackage

// >>> core/tfm_sync.sv
/*
 Two-stage synchroniser for level pins entering the clock domain.
 Assumes the inputs are slow levels; each bit is synchronised on its own.
*/
`timescale 1ns/10ps
module tfm_sync
	import tfm_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [SYNC_W-1:0] async,
	output logic [SYNC_W-1:0] synced
);

	logic [SYNC_W-1:0] stage1_reg;
	logic [SYNC_W-1:0] stage2_reg;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
		end else begin
			stage1_reg <= async;
			stage2_reg <= stage1_reg;
		end
	end

	assign synced = stage2_reg;

endmodule

// >>> tb/tb_top.sv
/*
 Self-checking testbench for the thermal fault monitor.
 Assumes the host model on the command port and one 10 MHz clock.
*/
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0, nrst = 1'b0, enPin = 1'b1, softStartActive = 1'b0, hicLatch = 1'b1;
	logic [15:0] thermistorVoltage = 16'h0400, rdData, cmdData, v;
	logic [7:0] dieTemp = 8'h19, cmdCode;
	logic cmdWrite, cmdRead, clearFaults, alertLineOut, alertLineOe, pwmEnable, softStartReq, latchedOff;
	int num_errors = 0, samples_checked = 0, cycles = 0, ssCount = 0, n;
	always #50 clk = ~clk;
	tfm_host host_u (.clk(clk), .rdData(rdData), .cmdCode(cmdCode), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
		.cmdData(cmdData), .clearFaults(clearFaults));
	tfm_monitor dut_u (.clk(clk), .nrst(nrst), .enPin(enPin), .hicLatchPin(hicLatch), .softStartActive(softStartActive),
		.thermistorVoltage(thermistorVoltage), .dieTemp(dieTemp), .cmdCode(cmdCode), .cmdWrite(cmdWrite),
		.cmdRead(cmdRead), .cmdData(cmdData), .clearFaults(clearFaults), .rdData(rdData),
		.alertLineOut(alertLineOut), .alertLineOe(alertLineOe), .pwmEnable(pwmEnable),
		.softStartReq(softStartReq), .latchedOff(latchedOff));
	task cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task bchk(input string nm, input logic e, input logic g);
		chk(nm, {15'h0000, e}, {15'h0000, g});
	endtask
	task rdchk(input logic [7:0] c, input logic [15:0] e);
		host_u.rd(c, v);
		chk($sformatf("reg %h", c), e, v);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Restart pulses counted mid-cycle, away from the launching edge
	always @(negedge clk) begin
		if (softStartReq === 1'b1) begin
			ssCount <= ssCount + 1;
		end
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			num_errors++;
			summarize();
		end
	end
	task t_warn;
		thermistorVoltage = 16'h01C1;
		cyc(3);
		rdchk(8'hD0, 16'h0000);
		softStartActive = 1'b1;
		cyc(3);
		rdchk(8'hD0, 16'h0002);
		bchk("pwm", 1'b1, pwmEnable);
		thermistorVoltage = 16'h0400;
		cyc(3);
		bchk("alert", 1'b1, alertLineOe);
		bchk("alert drive", 1'b0, alertLineOut);
		host_u.wr(8'hD0, 16'h0002);
		cyc(2);
		bchk("alert", 1'b0, alertLineOe);
		thermistorVoltage = 16'h012B;
		cyc(3);
		rdchk(8'hD0, 16'h000A);
		bchk("pwm", 1'b1, pwmEnable);
		thermistorVoltage = 16'h0400;
		host_u.clr();
		rdchk(8'hD0, 16'h0000);
		$display("t_warn done");
	endtask
	task t_limits;
		host_u.wr(8'h51, 16'h0200);
		host_u.wr(8'h4F, 16'h0150);
		rdchk(8'h4F, 16'h0150);
		thermistorVoltage = 16'h014F;
		cyc(3);
		rdchk(8'hD0, 16'h000A);
		thermistorVoltage = 16'h0150;
		host_u.wr(8'hD0, 16'h000A);
		rdchk(8'hD0, 16'h0002);
		thermistorVoltage = 16'h0400;
		host_u.wr(8'hD0, 16'h0002);
		$display("t_limits done");
	endtask
	task t_protect;
		host_u.wr(8'hD1, 16'h0000);
		thermistorVoltage = 16'h0100;
		cyc(3);
		bchk("pwm", 1'b0, pwmEnable);
		bchk("latched", 1'b0, latchedOff);
		n = ssCount;
		thermistorVoltage = 16'h0400;
		cyc(4);
		bchk("pwm", 1'b1, pwmEnable);
		chk("restarts", 16'(n + 1), 16'(ssCount));
		dieTemp = 8'hA0;
		cyc(2);
		bchk("pwm", 1'b0, pwmEnable);
		dieTemp = 8'h91;
		cyc(3);
		bchk("pwm", 1'b0, pwmEnable);
		n = ssCount;
		dieTemp = 8'h90;
		cyc(3);
		bchk("pwm", 1'b1, pwmEnable);
		chk("restarts", 16'(n + 1), 16'(ssCount));
		host_u.wr(8'hD2, 16'h0000);
		thermistorVoltage = 16'h0100;
		cyc(3);
		bchk("latched", 1'b1, latchedOff);
		thermistorVoltage = 16'h0400;
		cyc(5);
		bchk("pwm", 1'b0, pwmEnable);
		enPin = 1'b0;
		hicLatch = 1'b0;
		cyc(4);
		enPin = 1'b1;
		cyc(5);
		bchk("pwm", 1'b1, pwmEnable);
		rdchk(8'hD0, 16'h0000);
		rdchk(8'hD1, 16'h0009);
		rdchk(8'hD2, 16'h0000);
		$display("t_protect done");
	endtask
	task t_reset;
		rdchk(8'h4F, 16'h012C);
		rdchk(8'h51, 16'h01C2);
		rdchk(8'hD1, 16'h0009);
		rdchk(8'hD2, 16'h03FF);
		rdchk(8'h00, 16'h0000);
		bchk("alert", 1'b0, alertLineOe);
		$display("t_reset done");
	endtask
	initial begin
		cyc(2);
		nrst = 1'b1;
		cyc(5);
		t_reset();
		t_warn();
		t_limits();
		t_protect();
		summarize();
	end
endmodule

// >>> tb/tfm_host.sv
/*
 Host model on the command port of the thermal fault monitor.
 Assumes one clock shared with the monitor; drives at falling edges.
*/
`timescale 1ns/10ps
module tfm_host (
	input wire logic clk,
	input wire logic [15:0] rdData,
	output logic [7:0] cmdCode,
	output logic cmdWrite,
	output logic cmdRead,
	output logic [15:0] cmdData,
	output logic clearFaults
);
	initial begin
		cmdCode = 8'h00;
		cmdWrite = 1'b0;
		cmdRead = 1'b0;
		cmdData = 16'h0000;
		clearFaults = 1'b0;
	end
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge clk);
		cmdCode = c;
		cmdData = d;
		cmdWrite = 1'b1;
		@(negedge clk);
		cmdWrite = 1'b0;
		cmdCode = ~c;
		cmdData = ~d;
	endtask
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		@(negedge clk);
		cmdCode = c;
		cmdRead = 1'b1;
		@(negedge clk);
		cmdRead = 1'b0;
		cmdCode = ~c;
		@(negedge clk);
		d = rdData;
	endtask
	task automatic clr;
		@(negedge clk);
		clearFaults = 1'b1;
		@(negedge clk);
		clearFaults = 1'b0;
	endtask
endmodule

// >>> tb/tfm_monitor_properties.sv
/*
 Assertion checker for the thermal fault monitor ports.
 Assumes limits are never set below their reset values.
*/
`timescale 1ns/10ps
module tfm_monitor_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic enPin,
	input wire logic softStartActive,
	input wire logic [15:0] thermistorVoltage,
	input wire logic [7:0] dieTemp,
	input wire logic [7:0] cmdCode,
	input wire logic cmdWrite,
	input wire logic cmdRead,
	input wire logic clearFaults,
	input wire logic [15:0] rdData,
	input wire logic alertLineOut,
	input wire logic alertLineOe,
	input wire logic pwmEnable,
	input wire logic softStartReq,
	input wire logic latchedOff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_fault_alert: assert property (enPin[*3] ##0 (softStartActive && thermistorVoltage < 16'h012C)
		|=> alertLineOe) else $error("alert not raised on low voltage");
	a_alert_sticky: assert property (enPin[*3] ##0 (alertLineOe && !cmdWrite && !clearFaults)
		|=> alertLineOe) else $error("alert dropped by itself");
	a_idle_quiet: assert property (!softStartActive && !alertLineOe |=> !alertLineOe)
		else $error("flag set before soft-start");
	a_alert_level: assert property (alertLineOut == 1'b0)
		else $error("alert drive value not low");
	a_die_stop: assert property (dieTemp >= 8'hA0 |=> !pwmEnable)
		else $error("pwm running while die hot");
	a_latch_hold: assert property (enPin[*3] ##0 latchedOff |=> latchedOff && !pwmEnable)
		else $error("latch-off left");
	a_pulse_once: assert property (softStartReq |=> !softStartReq)
		else $error("restart pulse too long");
	a_warn_runs: assert property (enPin[*3] ##0 (pwmEnable && thermistorVoltage >= 16'h0150 && dieTemp < 8'hA0)
		|=> pwmEnable) else $error("pwm stopped without fault");
	a_unmapped_rd: assert property (enPin[*3] ##0 (cmdRead && cmdCode == 8'h00) |=> rdData == 16'h0000)
		else $error("unmapped read not zero");
endmodule
bind tfm_monitor tfm_monitor_chk chk_u (.clk(clk), .nrst(nrst), .enPin(enPin), .softStartActive(softStartActive),
	.thermistorVoltage(thermistorVoltage), .dieTemp(dieTemp), .cmdCode(cmdCode), .cmdWrite(cmdWrite),
	.cmdRead(cmdRead), .clearFaults(clearFaults), .rdData(rdData), .alertLineOut(alertLineOut),
	.alertLineOe(alertLineOe), .pwmEnable(pwmEnable), .softStartReq(softStartReq), .latchedOff(latchedOff));
